// ### hdl/uart_cfg_defines.svh
// register offsets, field positions and reset values of the frame and interrupt control block
`ifndef UART_CFG_DEFINES_SVH
`define UART_CFG_DEFINES_SVH
`define CTRL_ONE_ADDR    4'h0
`define CTRL_TWO_ADDR    4'h4
`define STATUS_ADDR      4'h8
`define CTRL_ONE_RESET   8'h00
`define CTRL_TWO_RESET   8'h00
`define C1_LOOP_BIT      7
`define C1_WAIT_BIT      6
`define C1_RXSRC_BIT     5
`define C1_LEN_BIT       4
`define C1_WAKE_BIT      3
`define C1_IDLE_STOP_BIT 2
`define C1_PAR_EN_BIT    1
`define C1_PAR_ODD_BIT   0
`define C2_TXE_IE_BIT    7
`define C2_TXD_IE_BIT    6
`define C2_RXF_IE_BIT    5
`define C2_IDLE_IE_BIT   4
`define C2_TX_ON_BIT     3
`define C2_RX_ON_BIT     2
`define IDLE_SHORT_BITS  4'ha
`define IDLE_LONG_BITS   4'hb
`endif

// ### hdl/uart_cfg_pkg.sv
// types shared by the frame and interrupt control block
package uart_cfg_pkg;
  typedef enum logic [1:0] {PATH_NORMAL, PATH_LOOP, PATH_SINGLE} path_e;
  typedef struct packed {
    logic loop_sel;
    logic freeze_wait;
    logic rx_src_sel;
    logic nine_bit;
    logic wake_addr;
    logic idle_after_stop;
    logic parity_en;
    logic parity_odd;
  } ctrl_one_s;
  typedef struct packed {
    logic tx_empty_ie;
    logic tx_done_ie;
    logic rx_full_ie;
    logic idle_ie;
    logic tx_on;
    logic rx_on;
    logic rsvd1;
    logic rsvd0;
  } ctrl_two_s;
  typedef struct packed {
    logic tx_empty;
    logic tx_done;
    logic rx_full;
    logic idle;
  } flags_s;
  typedef struct packed {
    logic       nine_bit;
    logic       parity_en;
    logic       parity_odd;
    logic       wake_addr;
    logic       idle_after_stop;
    logic [3:0] idle_bits;
  } frame_cfg_s;
endpackage

// ### hdl/uart_parity.sv
// parity bit generator and checker for one character
`timescale 1ns/1ps
module uart_parity (
  // character
  input  wire logic [8:0] data_i,
  input  wire logic       nine_bit_i,
  input  wire logic       odd_i,
  // results
  output logic            gen_bit_o,
  output logic            ok_o
);
  logic [7:0] body;
  logic       msb;
  always_comb begin
    body = nine_bit_i ? data_i[7:0] : {1'b0, data_i[6:0]};
    msb  = nine_bit_i ? data_i[8] : data_i[7];
    gen_bit_o = (^body) ^ odd_i;
    ok_o      = ((^body) ^ msb) == odd_i;
  end
endmodule

// ### hdl/uart_frame_ctrl.sv
// frame configuration, pin routing and interrupt request for an async serial port
`timescale 1ns/1ps
`include "uart_cfg_defines.svh"
module uart_frame_ctrl (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [3:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  output logic                         err_o,
  // core side
  input  wire uart_cfg_pkg::flags_s    flags_i,
  input  wire logic                    tx_serial_i,
  input  wire logic                    single_line_direction_i,
  input  wire logic                    wait_mode_i,
  input  wire logic [8:0]              char_i,
  output uart_cfg_pkg::frame_cfg_s     frame_o,
  output logic                         parity_bit_o,
  output logic                         parity_ok_o,
  output logic                         serial_clk_en_o,
  output logic                         irq_o,
  // pins
  input  wire logic                    rxd_i,
  input  wire logic                    txd_i,
  output logic                         txd_o,
  output logic                         txd_oe_o,
  output logic                         rxd_owned_o,
  output logic                         rx_serial_o
);
  import uart_cfg_pkg::*;

  ctrl_one_s  c1_ff, nxt_c1;
  ctrl_two_s  c2_ff, nxt_c2;
  logic       ack_ff, nxt_ack;
  logic       err_ff, nxt_err;
  logic [31:0] rd_ff, nxt_rd;
  frame_cfg_s frame_ff, nxt_frame;
  logic       gen_bit, chk_ok;
  logic       par_ff, nxt_par;
  logic       pok_ff, nxt_pok;
  logic       clken_ff, nxt_clken;
  logic       irq_ff, nxt_irq;
  logic       txd_ff, nxt_txd;
  logic       txoe_ff, nxt_txoe;
  logic       rxown_ff, nxt_rxown;
  logic       rxs_ff, nxt_rxs;
  path_e      path;
  logic       req, hit1, hit2, hits;

  //////////////////////////////////////////////////////////////////////////
  // register bus
  always_comb begin
    req     = cyc_i && stb_i && !ack_ff && !err_ff;
    hit1    = adr_i == `CTRL_ONE_ADDR;
    hit2    = adr_i == `CTRL_TWO_ADDR;
    hits    = adr_i == `STATUS_ADDR;
    nxt_c1  = c1_ff;
    nxt_c2  = c2_ff;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    nxt_rd  = 32'h0000_0000;
    if (req) begin
      if (hit1 || hit2 || hits) begin
        nxt_ack = 1'b1;
      end else begin
        nxt_err = 1'b1;
      end
      if (we_i && sel_i[0] && hit1) begin
        nxt_c1 = ctrl_one_s'(dat_i[7:0]);
      end
      if (we_i && sel_i[0] && hit2) begin
        nxt_c2 = ctrl_two_s'(dat_i[7:0]);
        nxt_c2.rsvd1 = 1'b0;
        nxt_c2.rsvd0 = 1'b0;
      end
      if (!we_i && hit1) begin
        nxt_rd = {24'h00_0000, c1_ff};
      end
      if (!we_i && hit2) begin
        nxt_rd = {24'h00_0000, c2_ff};
      end
      if (!we_i && hits) begin
        nxt_rd = {28'h000_0000, flags_i};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_ff  <= `CTRL_ONE_RESET;
      c2_ff  <= `CTRL_TWO_RESET;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rd_ff  <= 32'h0000_0000;
    end else begin
      c1_ff  <= nxt_c1;
      c2_ff  <= nxt_c2;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      rd_ff  <= nxt_rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // frame settings and parity
  uart_parity u_parity (
    .data_i     (char_i),
    .nine_bit_i (c1_ff.nine_bit),
    .odd_i      (c1_ff.parity_odd),
    .gen_bit_o  (gen_bit),
    .ok_o       (chk_ok)
  );

  always_comb begin
    nxt_frame.nine_bit        = c1_ff.nine_bit;
    nxt_frame.parity_en       = c1_ff.parity_en;
    nxt_frame.parity_odd      = c1_ff.parity_odd;
    nxt_frame.wake_addr       = c1_ff.wake_addr;
    nxt_frame.idle_after_stop = c1_ff.idle_after_stop;
    nxt_frame.idle_bits       = c1_ff.nine_bit ? `IDLE_LONG_BITS : `IDLE_SHORT_BITS;
    // with parity off the msb is plain data and is always accepted
    nxt_par = c1_ff.parity_en ? gen_bit : char_i[c1_ff.nine_bit ? 8 : 7];
    nxt_pok = c1_ff.parity_en ? chk_ok : 1'b1;
    // clocks run in wait unless freeze_wait is set, so a flag can still wake the cpu
    nxt_clken = !(wait_mode_i && c1_ff.freeze_wait);
  end

  //////////////////////////////////////////////////////////////////////////
  // pin routing
  always_comb begin
    // source select only matters with loop set
    if (!c1_ff.loop_sel) begin
      path = PATH_NORMAL;
    end else if (c1_ff.rx_src_sel) begin
      path = PATH_SINGLE;
    end else begin
      path = PATH_LOOP;
    end
    nxt_txd   = tx_serial_i;
    nxt_txoe  = c2_ff.tx_on;
    nxt_rxown = 1'b0;
    nxt_rxs   = 1'b1;
    unique case (path)
      PATH_NORMAL: begin
        nxt_rxown = c2_ff.rx_on;
        nxt_rxs   = rxd_i;
      end
      PATH_LOOP: begin
        nxt_rxs = tx_serial_i;
      end
      PATH_SINGLE: begin
        nxt_txoe = c2_ff.tx_on && single_line_direction_i;
        nxt_rxs  = nxt_txoe ? tx_serial_i : txd_i;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt request
  always_comb begin
    nxt_irq = (flags_i.tx_empty && c2_ff.tx_empty_ie)
           || (flags_i.tx_done  && c2_ff.tx_done_ie)
           || (flags_i.rx_full  && c2_ff.rx_full_ie)
           || (flags_i.idle     && c2_ff.idle_ie);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_ff <= '0;
      par_ff   <= 1'b0;
      pok_ff   <= 1'b1;
      clken_ff <= 1'b1;
      irq_ff   <= 1'b0;
      txd_ff   <= 1'b1;
      txoe_ff  <= 1'b0;
      rxown_ff <= 1'b0;
      rxs_ff   <= 1'b1;
    end else begin
      frame_ff <= nxt_frame;
      par_ff   <= nxt_par;
      pok_ff   <= nxt_pok;
      clken_ff <= nxt_clken;
      irq_ff   <= nxt_irq;
      txd_ff   <= nxt_txd;
      txoe_ff  <= nxt_txoe;
      rxown_ff <= nxt_rxown;
      rxs_ff   <= nxt_rxs;
    end
  end

  assign dat_o           = rd_ff;
  assign ack_o           = ack_ff;
  assign err_o           = err_ff;
  assign frame_o         = frame_ff;
  assign parity_bit_o    = par_ff;
  assign parity_ok_o     = pok_ff;
  assign serial_clk_en_o = clken_ff;
  assign irq_o           = irq_ff;
  assign txd_o           = txd_ff;
  assign txd_oe_o        = txoe_ff;
  assign rxd_owned_o     = rxown_ff;
  assign rx_serial_o     = rxs_ff;

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_loop_feeds_rx: assert property (@(posedge clk_i) disable iff (rst_i)
    c1_ff.loop_sel && !c1_ff.rx_src_sel |=> rx_serial_o == $past(tx_serial_i))
    else $error("loopback does not feed receiver");
  a_normal_uses_rxd: assert property (@(posedge clk_i) disable iff (rst_i)
    !c1_ff.loop_sel |=> rx_serial_o == $past(rxd_i))
    else $error("normal mode not using receive pin");
  a_rx_pin_freed: assert property (@(posedge clk_i) disable iff (rst_i)
    c1_ff.loop_sel |=> !rxd_owned_o)
    else $error("receive pin held in loop mode");
  a_freeze_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_mode_i && c1_ff.freeze_wait |=> !serial_clk_en_o)
    else $error("clocks not frozen in wait");
  a_run_in_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    !c1_ff.freeze_wait |=> serial_clk_en_o)
    else $error("clocks stopped with freeze clear");
  a_single_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    c1_ff.loop_sel && c1_ff.rx_src_sel && !single_line_direction_i |=> !txd_oe_o)
    else $error("single wire drives while receiving");
  a_no_parity_chk: assert property (@(posedge clk_i) disable iff (rst_i)
    !c1_ff.parity_en |=> parity_ok_o)
    else $error("parity checked while disabled");
  a_len_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 frame_o.nine_bit == $past(c1_ff.nine_bit))
    else $error("frame length not following control");
  a_irq_rx_full: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_i.rx_full && c2_ff.rx_full_ie |=> irq_o)
    else $error("rx full interrupt missing");
  a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    c2_ff[7:4] == 4'h0 |=> !irq_o)
    else $error("interrupt with all enables clear");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && hit2 && !ack_o |=> ack_o ##1 !ack_o)
    else $error("second control access not answered");
  c_single_wire: cover property (@(posedge clk_i) path == PATH_SINGLE && txd_oe_o);
  c_loopback: cover property (@(posedge clk_i) path == PATH_LOOP);
  c_irq: cover property (@(posedge clk_i) irq_o);
  c_write_one: cover property (@(posedge clk_i) ack_o && we_i && hit1);
endmodule

// ### verification/remote_node.sv
// remote serial node that sends one character on its line
`timescale 1ns/1ps
module remote_node (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // request
  input  wire logic       go_i,
  input  wire logic       nine_i,
  input  wire logic [8:0] data_i,
  // line
  output logic            line_o
);
  logic [10:0] sh_ff;
  logic [3:0]  cnt_ff;
  ////////////////////////////////////////////////////////////////
  // one bit per clock keeps runs short; line idles high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 4'h0;
      line_o <= 1'b1;
    end else if (go_i && cnt_ff == 4'h0) begin
      sh_ff  <= {1'b1, nine_i ? data_i[8] : 1'b1, data_i[7:0], 1'b0};
      cnt_ff <= 4'hb;
    end else if (cnt_ff != 4'h0) begin
      line_o <= sh_ff[0];
      sh_ff  <= {1'b1, sh_ff[10:1]};
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule

// ### verification/test_uart_frame_ctrl.sv
// bench for the frame and interrupt control block
`timescale 1ns/1ps
`include "uart_cfg_defines.svh"
module test_uart_frame_ctrl;
  import uart_cfg_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic        tx_ser = 0, dir = 0, wt = 0, go = 0, bus_err;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [8:0]  chr = 9'h000;
  flags_s      flags = 4'h0;
  frame_cfg_s  frame;
  logic        ack, err, txd_o, txd_oe, owned, rx_ser, clk_en, irq;
  logic        par_bit, par_ok, rem_line, txd_w;
  int          n_errors = 0, checks = 0;
  assign txd_w = txd_oe ? txd_o : rem_line;
  always #5 clk_i = ~clk_i;
  uart_frame_ctrl u_uart_frame_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack),
    .err_o(err), .flags_i(flags), .tx_serial_i(tx_ser), .single_line_direction_i(dir),
    .wait_mode_i(wt), .char_i(chr), .frame_o(frame), .parity_bit_o(par_bit),
    .parity_ok_o(par_ok), .serial_clk_en_o(clk_en), .irq_o(irq), .rxd_i(rem_line),
    .txd_i(txd_w), .txd_o(txd_o), .txd_oe_o(txd_oe), .rxd_owned_o(owned), .rx_serial_o(rx_ser));
  remote_node u_remote_node (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .nine_i(1'b1),
    .data_i(9'h135), .line_o(rem_line));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk_i);
    end while (!(ack | err));
    rd = dat_o;
    bus_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // outputs lag the register by one edge
  task settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task watch(input logic on_txd);
    logic prev;
    @(posedge clk_i) go <= 1'b1;
    @(posedge clk_i) go <= 1'b0;
    #1;
    repeat (13) begin
      prev = on_txd ? txd_w : rem_line;
      @(posedge clk_i);
      #1;
      chk(rx_ser, prev);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    wb(0, `CTRL_ONE_ADDR, 8'h00);
    chk(rd, 32'h0);
    wb(0, `CTRL_TWO_ADDR, 8'h00);
    chk(rd, 32'h0);
    chk({irq, clk_en, owned}, 3'b010);
    $display("reset test done");
  endtask
  task t_regs;
    wb(1, `CTRL_ONE_ADDR, 8'ha5);
    wb(0, `CTRL_ONE_ADDR, 8'h00);
    chk(rd, 32'ha5);
    wb(1, `CTRL_ONE_ADDR, 8'h5a);
    wb(0, `CTRL_ONE_ADDR, 8'h00);
    chk(rd, 32'h5a);
    wb(1, `CTRL_TWO_ADDR, 8'hff);
    wb(0, `CTRL_TWO_ADDR, 8'h00);
    chk(rd, 32'hfc);
    wb(0, 4'hc, 8'h00);
    chk(bus_err, 1'b1);
    wb(1, `CTRL_TWO_ADDR, 8'h00);
    $display("register test done");
  endtask
  task t_frame;
    for (int i = 0; i < 4; i++) begin
      wb(1, `CTRL_ONE_ADDR, {3'b0, i[0], i[1], i[0] ^ i[1], 2'b0});
      settle;
      chk(32'(frame), 32'({i[0], 2'b0, i[1], i[0] ^ i[1], i[0] ? 4'hb : 4'ha}));
    end
    $display("frame test done");
  endtask
  task t_parity;
    logic [8:0] c;
    logic       msb, ones, par_all;
    for (int k = 0; k < 16; k++) begin
      c = k[3] ? 9'h0c3 : 9'h1a5;
      @(posedge clk_i) chr <= c;
      wb(1, `CTRL_ONE_ADDR, {3'b0, k[0], 2'b0, k[1], k[2]});
      settle;
      msb = k[0] ? c[8] : c[7];
      ones = k[0] ? ^c[7:0] : ^c[6:0];
      par_all = k[0] ? ^c : ^c[7:0];
      chk(par_bit, k[1] ? ones ^ k[2] : msb);
      chk(par_ok, k[1] ? par_all == k[2] : 1'b1);
    end
    $display("parity test done");
  endtask
  task t_wait;
    @(posedge clk_i) wt <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      wb(1, `CTRL_ONE_ADDR, f[0] ? 8'h40 : 8'h00);
      settle;
      chk(clk_en, !f[0]);
    end
    @(posedge clk_i) wt <= 1'b0;
    settle;
    chk(clk_en, 1'b1);
    $display("wait test done");
  endtask
  task t_route;
    wb(1, `CTRL_TWO_ADDR, 8'h0c);
    for (int s = 0; s < 2; s++) begin
      wb(1, `CTRL_ONE_ADDR, s[0] ? 8'h20 : 8'h00);
      settle;
      chk(owned, 1'b1);
      watch(1'b0);
    end
    wb(1, `CTRL_ONE_ADDR, 8'h80);
    @(posedge clk_i) tx_ser <= 1'b0;
    settle;
    chk({rx_ser, owned, txd_oe}, 3'b001);
    @(posedge clk_i) tx_ser <= 1'b1;
    settle;
    chk(rx_ser, 1'b1);
    wb(1, `CTRL_ONE_ADDR, 8'ha0);
    @(posedge clk_i) dir <= 1'b1;
    settle;
    chk({txd_oe, txd_o, rx_ser, owned}, 4'b1110);
    @(posedge clk_i) dir <= 1'b0;
    settle;
    chk(txd_oe, 1'b0);
    watch(1'b1);
    wb(1, `CTRL_ONE_ADDR, 8'h00);
    $display("routing test done");
  endtask
  task t_irq;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) flags <= 4'hf & ~(4'h1 << i);
      wb(1, `CTRL_TWO_ADDR, 8'h10 << i);
      settle;
      chk(irq, 1'b0);
      @(posedge clk_i) flags <= 4'h1 << i;
      settle;
      chk(irq, 1'b1);
      wb(1, `CTRL_TWO_ADDR, ~(8'h10 << i) & 8'hf0);
      settle;
      chk(irq, 1'b0);
    end
    $display("interrupt test done");
  endtask
  ////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_regs;
    t_frame;
    t_parity;
    t_wait;
    t_route;
    t_irq;
    end_of_test;
  end
  // tests need well under 2000 cycles
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
endmodule
